// File: parity_ram.sv
// one small sram with a data word and its stored parity bits
// assumes the caller provides byte parity or injected parity per write
`timescale 1ns/100ps
module parity_ram #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          core_clk_i,
	input  wire logic          clk_en_i,
	input  wire logic          wr_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [31:0]   wdata_i,
	input  wire logic [3:0]    wpar_i,
	output logic      [31:0]   rdata_o,
	output logic      [3:0]    rpar_o
);
	logic [31:0] data_mem [DEPTH];
	logic [3:0]  par_mem  [DEPTH];

	// no reset: array contents are undefined until written
	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			if (wr_i) begin
				data_mem[addr_i] <= wdata_i;
				par_mem[addr_i]  <= wpar_i;
			end
			rdata_o <= data_mem[addr_i];
			rpar_o  <= par_mem[addr_i];
		end
	end
endmodule : parity_ram

// File: parity_test_pkg.sv
// Behaviour
// - software can implant chosen parity bits into selected SRAM cells
// - one or more target memories are chosen by a select mask; injection applies only there
// - pattern register parity value is stored with every write to a selected target while armed
// - parity read field returns stored parity of accessed cell, synced
// - errors and traps are raised only for memories enabled for them
// - buffered sram write is committed when the next write to the program or data sram arrives
// - parity mismatch on read flags an error if error-enabled and, if also trap-enabled, a trap
// - errors go to error flag register, trap to trap status register
//
// package of constants for the sram parity self-test block
// assumes an apb master on the system clock
package parity_test_pkg;
	// ****************************************
	// memory targets
	// ****************************************
	localparam int NUM_MEM       = 5;
	localparam int MEM_PROG      = 0;
	localparam int MEM_DATA      = 1;
	localparam int MEM_SERIAL    = 2;
	localparam int MEM_CAN       = 3;
	localparam int MEM_USB       = 4;
	localparam int PAR_W         = 4;
	localparam int ADDR_W        = 6;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFF_PATTERN = 8'h00;
	localparam logic [7:0] OFF_SELECT  = 8'h04;
	localparam logic [7:0] OFF_MCHK    = 8'h08;
	localparam logic [7:0] OFF_ERR_EN  = 8'h0c;
	localparam logic [7:0] OFF_TRAP_EN = 8'h10;
	localparam logic [7:0] OFF_ERR_FLG = 8'h14;
	localparam logic [7:0] OFF_TRAP_ST = 8'h18;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h1c;
	localparam logic [7:0] OFF_MEM_ADR = 8'h20;
	localparam logic [7:0] OFF_MEM_DAT = 8'h24;
	// ****************************************
	// field positions
	// ****************************************
	localparam int PWR_LSB      = 0;
	localparam int PRD_LSB      = 8;
	localparam int MCHK_EN_BIT  = 0;
	localparam int TRAP_NMI_BIT = 0;
	localparam int IRQ_ERR_BIT  = 0;
	localparam int IRQ_TRAP_BIT = 1;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : parity_test_pkg

// File: sram_parity_injection_test.sv
// parity self-test for five on-chip srams behind an apb register slave
// assumes software drives apb on core_clk_i; one clock domain
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
module sram_parity_injection_test #(
	parameter int DEPTH = 64
) (
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        clk_en_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             nmi_trap_o,
	output logic             irq_o
);
	localparam int N  = parity_test_pkg::NUM_MEM;
	localparam int AW = parity_test_pkg::ADDR_W;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] byte_par(input logic [31:0] d);
		byte_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
	endfunction : byte_par

	// ****************************************
	// apb decode
	// ****************************************
	logic wr_acc;
	logic rd_acc;
	logic known;
	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	always_comb begin
		unique case (paddr)
			parity_test_pkg::OFF_PATTERN, parity_test_pkg::OFF_SELECT,
			parity_test_pkg::OFF_MCHK, parity_test_pkg::OFF_ERR_EN,
			parity_test_pkg::OFF_TRAP_EN, parity_test_pkg::OFF_ERR_FLG,
			parity_test_pkg::OFF_TRAP_ST, parity_test_pkg::OFF_IRQ_MSK,
			parity_test_pkg::OFF_MEM_ADR,
			parity_test_pkg::OFF_MEM_DAT: known = 1'b1;
			default:                      known = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !known;

	// ****************************************
	// control registers
	// ****************************************
	logic [3:0]    pwr_q, pwr_d;
	logic [3:0]    prd_q, prd_d;
	logic [N-1:0]  sel_q, sel_d;
	logic          mchk_q, mchk_d;
	logic [N-1:0]  err_en_q, err_en_d;
	logic [N-1:0]  trap_en_q, trap_en_d;
	logic [N-1:0]  err_flg_q, err_flg_d;
	logic          trap_q, trap_d;
	logic [1:0]    msk_q, msk_d;
	logic [2:0]    mem_q, mem_d;
	logic [AW-1:0] adr_q, adr_d;
	logic [31:0]   prdata_d;

	// ****************************************
	// memory access and write buffer
	// ****************************************
	logic          dat_wr;
	logic          dat_rd;
	logic          buf_v_q, buf_v_d;
	logic [2:0]    buf_m_q, buf_m_d;
	logic [AW-1:0] buf_a_q, buf_a_d;
	logic [31:0]   buf_w_q, buf_w_d;
	logic [3:0]    buf_p_q, buf_p_d;
	logic          chk_q, chk_d;
	logic [2:0]    chk_m_q, chk_m_d;
	logic [N-1:0]  mem_wr;
	logic [AW-1:0] mem_ad [N];
	logic [31:0]   mem_wd [N];
	logic [3:0]    mem_wp [N];
	logic [31:0]   mem_rd [N];
	logic [3:0]    mem_rp [N];
	logic          inj_here;
	logic [3:0]    wpar;
	logic          buffered;
	logic          mismatch;

	assign dat_wr   = wr_acc && paddr == parity_test_pkg::OFF_MEM_DAT;
	assign dat_rd   = rd_acc && paddr == parity_test_pkg::OFF_MEM_DAT;
	// injection only when armed and only into memories set in the select mask
	assign inj_here = mchk_q && sel_q[mem_q];
	assign wpar     = inj_here ? pwr_q : byte_par(pwdata);
	// program and data srams post writes through a one-deep buffer
	assign buffered = mem_q == 3'(parity_test_pkg::MEM_PROG)
		|| mem_q == 3'(parity_test_pkg::MEM_DATA);

	always_comb begin
		buf_v_d = buf_v_q;
		buf_m_d = buf_m_q;
		buf_a_d = buf_a_q;
		buf_w_d = buf_w_q;
		buf_p_d = buf_p_q;
		chk_d   = 1'b0;
		chk_m_d = chk_m_q;
		mem_wr  = '0;
		for (int i = 0; i < N; i++) begin
			mem_ad[i] = adr_q;
			mem_wd[i] = pwdata;
			mem_wp[i] = wpar;
		end
		if (dat_wr) begin
			if (buffered) begin
				// previous posted write retires on this one
				if (buf_v_q) begin
					mem_wr[buf_m_q] = 1'b1;
					mem_ad[buf_m_q] = buf_a_q;
					mem_wd[buf_m_q] = buf_w_q;
					mem_wp[buf_m_q] = buf_p_q;
				end
				buf_v_d = 1'b1;
				buf_m_d = mem_q;
				buf_a_d = adr_q;
				buf_w_d = pwdata;
				buf_p_d = wpar;
			end else begin
				mem_wr[mem_q] = 1'b1;
			end
		end
		if (dat_rd) begin
			chk_d   = 1'b1;
			chk_m_d = mem_q;
		end
	end

	// ram read data lands one cycle after the read access
	assign mismatch = chk_q && byte_par(mem_rd[chk_m_q]) != mem_rp[chk_m_q];

	// ****************************************
	// register next state
	// ****************************************
	always_comb begin
		pwr_d     = pwr_q;
		prd_d     = prd_q;
		sel_d     = sel_q;
		mchk_d    = mchk_q;
		err_en_d  = err_en_q;
		trap_en_d = trap_en_q;
		msk_d     = msk_q;
		mem_d     = mem_q;
		adr_d     = adr_q;
		err_flg_d = err_flg_q;
		trap_d    = trap_q;
		prdata_d  = parity_test_pkg::RST_ZERO;
		if (chk_q) begin
			prd_d = mem_rp[chk_m_q];
		end
		if (wr_acc) begin
			unique case (paddr)
				parity_test_pkg::OFF_PATTERN:
					pwr_d = pwdata[parity_test_pkg::PWR_LSB +: 4];
				parity_test_pkg::OFF_SELECT:  sel_d = pwdata[N-1:0];
				parity_test_pkg::OFF_MCHK:
					mchk_d = pwdata[parity_test_pkg::MCHK_EN_BIT];
				parity_test_pkg::OFF_ERR_EN:  err_en_d = pwdata[N-1:0];
				parity_test_pkg::OFF_TRAP_EN: trap_en_d = pwdata[N-1:0];
				parity_test_pkg::OFF_IRQ_MSK: msk_d = pwdata[1:0];
				parity_test_pkg::OFF_MEM_ADR: begin
					mem_d = pwdata[18:16];
					adr_d = pwdata[AW-1:0];
				end
				parity_test_pkg::OFF_ERR_FLG:
					err_flg_d = err_flg_q & ~pwdata[N-1:0];
				parity_test_pkg::OFF_TRAP_ST:
					trap_d = trap_q & ~pwdata[parity_test_pkg::TRAP_NMI_BIT];
				default: ;
			endcase
		end
		// a new error beats a clear in the same cycle
		if (mismatch && err_en_q[chk_m_q]) begin
			err_flg_d[chk_m_q] = 1'b1;
			if (trap_en_q[chk_m_q]) begin
				trap_d = 1'b1;
			end
		end
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				parity_test_pkg::OFF_PATTERN: begin
					prdata_d[parity_test_pkg::PWR_LSB +: 4] = pwr_q;
					prdata_d[parity_test_pkg::PRD_LSB +: 4] = prd_q;
				end
				parity_test_pkg::OFF_SELECT:  prdata_d[N-1:0] = sel_q;
				parity_test_pkg::OFF_MCHK:    prdata_d[0] = mchk_q;
				parity_test_pkg::OFF_ERR_EN:  prdata_d[N-1:0] = err_en_q;
				parity_test_pkg::OFF_TRAP_EN: prdata_d[N-1:0] = trap_en_q;
				parity_test_pkg::OFF_ERR_FLG: prdata_d[N-1:0] = err_flg_q;
				parity_test_pkg::OFF_TRAP_ST: prdata_d[0] = trap_q;
				parity_test_pkg::OFF_IRQ_MSK: prdata_d[1:0] = msk_q;
				parity_test_pkg::OFF_MEM_ADR: begin
					prdata_d[18:16]  = mem_q;
					prdata_d[AW-1:0] = adr_q;
				end
				// ram output follows the address register, so the word
				// is already there in the setup cycle
				parity_test_pkg::OFF_MEM_DAT: prdata_d = mem_rd[mem_q];
				default: ;
			endcase
		end
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwr_q     <= '0;
			prd_q     <= '0;
			sel_q     <= '0;
			mchk_q    <= 1'b0;
			err_en_q  <= '0;
			trap_en_q <= '0;
			err_flg_q <= '0;
			trap_q    <= 1'b0;
			msk_q     <= '0;
			mem_q     <= '0;
			adr_q     <= '0;
			prdata    <= parity_test_pkg::RST_ZERO;
			buf_v_q   <= 1'b0;
			buf_m_q   <= '0;
			buf_a_q   <= '0;
			buf_w_q   <= parity_test_pkg::RST_ZERO;
			buf_p_q   <= '0;
			chk_q     <= 1'b0;
			chk_m_q   <= '0;
		end else if (clk_en_i) begin
			pwr_q     <= pwr_d;
			prd_q     <= prd_d;
			sel_q     <= sel_d;
			mchk_q    <= mchk_d;
			err_en_q  <= err_en_d;
			trap_en_q <= trap_en_d;
			err_flg_q <= err_flg_d;
			trap_q    <= trap_d;
			msk_q     <= msk_d;
			mem_q     <= mem_d;
			adr_q     <= adr_d;
			prdata    <= prdata_d;
			buf_v_q   <= buf_v_d;
			buf_m_q   <= buf_m_d;
			buf_a_q   <= buf_a_d;
			buf_w_q   <= buf_w_d;
			buf_p_q   <= buf_p_d;
			chk_q     <= chk_d;
			chk_m_q   <= chk_m_d;
		end
	end

	// ****************************************
	// memories
	// ****************************************
	for (genvar g = 0; g < N; g++) begin : g_mem
		parity_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
			.core_clk_i (core_clk_i),
			.clk_en_i   (clk_en_i),
			.wr_i       (mem_wr[g]),
			.addr_i     (mem_ad[g]),
			.wdata_i    (mem_wd[g]),
			.wpar_i     (mem_wp[g]),
			.rdata_o    (mem_rd[g]),
			.rpar_o     (mem_rp[g])
		);
	end

	assign nmi_trap_o = trap_q;
	assign irq_o = (|err_flg_q && msk_q[parity_test_pkg::IRQ_ERR_BIT])
		|| (trap_q && msk_q[parity_test_pkg::IRQ_TRAP_BIT]);

	// ****************************************
	// checks
	// ****************************************
	AST_ERR_SET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		clk_en_i && mismatch && err_en_q[chk_m_q]
		|=> err_flg_q[$past(chk_m_q)])
		else $error("parity mismatch not flagged");
	AST_NO_ERR_DIS: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		clk_en_i && !wr_acc && !(mismatch && err_en_q[chk_m_q])
		|=> err_flg_q == $past(err_flg_q))
		else $error("error flag changed without cause");
	AST_STICKY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		trap_q && !(wr_acc && paddr == parity_test_pkg::OFF_TRAP_ST)
		|=> trap_q)
		else $error("trap flag dropped without clear");
	AST_TRAP: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		clk_en_i && mismatch && err_en_q[chk_m_q] && trap_en_q[chk_m_q]
		|=> nmi_trap_o)
		else $error("trap not raised");
	AST_INJECT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		dat_wr && !buffered && inj_here |-> mem_wp[mem_q] == pwr_q)
		else $error("injected parity not used");
	AST_ONLY_SEL: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		dat_wr && !buffered && !sel_q[mem_q]
		|-> mem_wp[mem_q] == byte_par(pwdata))
		else $error("parity injected into unselected memory");
	AST_FLUSH: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		dat_wr && buffered && buf_v_q |-> mem_wr[buf_m_q])
		else $error("buffered write not committed");
	AST_PRD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		clk_en_i && chk_q |=> prd_q == $past(mem_rp[chk_m_q]))
		else $error("parity readback not captured");
endmodule : sram_parity_injection_test

// File: testbench.sv
// self-checking bench for the sram parity self-test block
// assumes a zero-wait apb slave and the register map of the package
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	// ****************************************
	// signals
	// ****************************************
	logic        core_clk_i;
	logic        resetn_i;
	logic        clk_en_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        nmi_trap_o;
	logic        irq_o;
	int          n_errors;
	int          check_count;
	int          cyc;
	int          seed;
	logic [31:0] rd;
	logic        er;

	sram_parity_injection_test #(.DEPTH(64)) i_dut (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_trap_o(nmi_trap_o), .irq_o(irq_o)
	);

	always #50 core_clk_i = ~core_clk_i;

	// ****************************************
	// closing and timeout
	// ****************************************
	task results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// whole run is well under a thousand transfers
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			results();
		end
	end

	// ****************************************
	// apb master
	// ****************************************
	// the answer is taken at the rising edge that sees pready high
	task apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge core_clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
			rdy = pready;
			rd  = prdata;
			er  = pslverr;
		end while (rdy !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer

	task apb_wr(input logic [7:0] a, input logic [31:0] d);
		apb_xfer(1'b1, a, d);
	endtask : apb_wr

	task apb_rd(input logic [7:0] a);
		apb_xfer(1'b0, a, 32'h0);
	endtask : apb_rd

	// ****************************************
	// reference model
	// ****************************************
	function automatic logic [3:0] bpar(input logic [31:0] d);
		logic [3:0] p;
		for (int i = 0; i < 4; i++)
			p[i] = ^d[8*i +: 8];
		return p;
	endfunction : bpar

	// one implant-write-read pass; model decides flags from select and enable
	task automatic do_case(input int m, input logic [4:0] sel,
			input logic [4:0] en);
		logic [31:0] d0;
		logic [3:0]  pw;
		int          a0;
		int          ef;
		d0 = $random(seed);
		pw = ~bpar(d0);
		a0 = $random(seed) & 63;
		ef = (sel[m] && en[m]) ? (1 << m) : 0;
		apb_wr(parity_test_pkg::OFF_ERR_EN, {27'h0, en});
		apb_wr(parity_test_pkg::OFF_TRAP_EN, {27'h0, en});
		apb_wr(parity_test_pkg::OFF_IRQ_MSK, 32'h3);
		apb_wr(parity_test_pkg::OFF_SELECT, {27'h0, sel});
		apb_wr(parity_test_pkg::OFF_MCHK, 32'h1);
		apb_wr(parity_test_pkg::OFF_PATTERN, {28'h0, pw});
		apb_wr(parity_test_pkg::OFF_MEM_ADR, 32'((m << 16) | a0));
		apb_wr(parity_test_pkg::OFF_MEM_DAT, d0);
		if (m < 2) begin
			apb_wr(parity_test_pkg::OFF_MEM_ADR, 32'((m << 16) | (a0 ^ 1)));
			apb_wr(parity_test_pkg::OFF_MEM_DAT, $random(seed));
		end
		apb_wr(parity_test_pkg::OFF_MCHK, 32'h0);
		apb_wr(parity_test_pkg::OFF_MEM_ADR, 32'((m << 16) | a0));
		apb_rd(parity_test_pkg::OFF_MEM_DAT);
		repeat (2) @(posedge core_clk_i);
		apb_rd(parity_test_pkg::OFF_MEM_DAT);
		`CHK("mem_data", d0, rd)
		repeat (6) @(posedge core_clk_i);
		apb_rd(parity_test_pkg::OFF_ERR_FLG);
		`CHK("err_flags", 32'(ef), rd)
		apb_rd(parity_test_pkg::OFF_TRAP_ST);
		`CHK("trap_status", 32'(ef != 0), rd)
		`CHK("nmi", 1'(ef != 0), nmi_trap_o)
		`CHK("irq", 1'(ef != 0), irq_o)
		apb_rd(parity_test_pkg::OFF_PATTERN);
		`CHK("par_read", (sel[m] ? pw : ~pw), rd[11:8])
		apb_wr(parity_test_pkg::OFF_ERR_FLG, 32'h1f);
		apb_wr(parity_test_pkg::OFF_TRAP_ST, 32'h1);
		apb_rd(parity_test_pkg::OFF_ERR_FLG);
		`CHK("err_clear", 32'h0, rd)
		`CHK("nmi_clear", 1'b0, nmi_trap_o)
		`CHK("irq_clear", 1'b0, irq_o)
	endtask : do_case

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		core_clk_i  = 1'b0;
		resetn_i    = 1'b0;
		clk_en_i    = 1'b1;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h0;
		n_errors    = 0;
		check_count = 0;
		cyc         = 0;
		seed        = 32'h796cccb5;
		repeat (3) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		for (int a = 0; a <= 32; a += 4) begin
			apb_rd(8'(a));
			`CHK("reset_value", 32'h0, rd)
		end
		apb_rd(8'h40);
		`CHK("unmapped_data", 32'h0, rd)
		`CHK("unmapped_err", 1'b1, er)
		for (int m = 0; m < parity_test_pkg::NUM_MEM; m++)
			do_case(m, 5'(1 << m), 5'h1f);
		do_case(2, 5'h00, 5'h1f);
		do_case(1, 5'h1f, 5'h1d);
		do_case(3, 5'h1f, 5'h1f);
		results();
	end
endmodule : testbench
